// *** verilog/iodr_pkg.sv ***
/*
  Constants shared by the inertial output and identification register block:
  register offsets, serial frame layout, sample clock and divider figures.
  Assumes a 125 MHz system clock and a 16-bit serial register frame.
*/
`default_nettype none
package iodr_pkg;
  // byte addresses as seen in the serial command word, bits [14:8]
  localparam logic [6:0] TEMPERATURE_OUTPUT_ADDR = 7'h1E;
  localparam logic [6:0] X_VELOCITY_CHANGE_ADDR = 7'h2A;
  localparam logic [6:0] Y_VELOCITY_CHANGE_ADDR = 7'h2C;
  localparam logic [6:0] Z_VELOCITY_CHANGE_ADDR = 7'h2E;
  localparam logic [6:0] LOT_CODE_FIRST_HALF_ADDR = 7'h52;
  localparam logic [6:0] LOT_CODE_SECOND_HALF_ADDR = 7'h54;
  localparam logic [6:0] PART_IDENTITY_ADDR = 7'h56;
  localparam logic [6:0] UNIT_SERIAL_NUMBER_ADDR = 7'h58;

  // serial frame: bit 15 set means write, [14:8] address
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] FRAME_BITS_COUNT = 5'h10;
  localparam int CMD_WRITE_BIT = 15;
  localparam int CMD_ADDR_HI = 14;
  localparam int CMD_ADDR_LO = 8;

  // sample clock selection
  localparam logic [1:0] CLK_MODE_INTERNAL = 2'h0;
  localparam longint CLK_HZ = 125000000;
  localparam longint INT_SAMPLE_HZ = 2048;
  localparam int INT_TICK_CYCLES = int'(CLK_HZ / INT_SAMPLE_HZ);

  // one delta-velocity step equals 0.25 mg x 10 x (decimation + 1) / sample rate, in mm/s
  localparam int DIV_STEPS = 32;
  localparam logic [5:0] DIV_STEPS_COUNT = 6'h20;
  localparam logic [31:0] VEL_POS_LIMIT = 32'h00007FFF;
  localparam logic [31:0] VEL_NEG_LIMIT = 32'h00008000;
  localparam logic [15:0] VEL_ZERO = 16'h0000;
  localparam logic [15:0] TEMP_ZERO = 16'h0000;
  localparam int SERIAL_BITS = 12;
endpackage : iodr_pkg
`default_nettype wire

// *** verilog/iodr_registers.sv ***
/*
  Read-only output and identification registers with their serial slave.
  Assumes per-sample velocity increments and temperature samples come from
  logic on clk, and that the serial clock is far slower than clk.
*/
// How it works
// - report velocity change per processing cycle
// - three 16-bit signed velocity registers, zero is zero
// - step scales with decimation plus one
// - internal 2048 Hz or external sample clock
// - each temperature sample loads the register
// - temperature signed, 0.05 C steps, 25 C zero
// - fixed part identity register
// - two lot halves form 32-bit code
// - serial number in low twelve bits
// - all registers read-only to the host
`timescale 1ns/1ps
`default_nettype none
module iodr_registers
  import iodr_pkg::*;
#(
  parameter int TICK_CYCLES = INT_TICK_CYCLES,
  parameter logic [15:0] PART_ID = 16'h1234, // arbitrary value
  parameter logic [15:0] LOT_FIRST = 16'hA5A5, // arbitrary value
  parameter logic [15:0] LOT_SECOND = 16'h5A5A, // arbitrary value
  parameter logic [15:0] SERIAL_CODE = 16'h0001 // arbitrary value
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] clockModeSel,
  input wire logic [15:0] decimationSetting,
  input wire logic extSampleClk,
  input wire logic [15:0] velIncX,
  input wire logic [15:0] velIncY,
  input wire logic [15:0] velIncZ,
  input wire logic tempValid,
  input wire logic [15:0] tempData,
  input wire logic sclk,
  input wire logic csN,
  input wire logic mosi,
  output logic miso,
  output logic misoEnable
);
  logic [2:0] extSync;
  logic [2:0] sclkSync;
  logic [2:0] csSync;
  logic [1:0] mosiSync;
  logic [31:0] intCount;
  logic intTick;
  logic extRise;
  logic sampleTick;
  logic [15:0] sampleCount;
  logic windowEnd;
  logic signed [31:0] accum [3];
  logic [31:0] magSave [3];
  logic [17:0] rem [3];
  logic [31:0] quo [3];
  logic [31:0] dvd [3];
  logic negSign [3];
  logic [16:0] divisor;
  logic [5:0] divCount;
  logic dvLoad;
  logic [15:0] velReg [3];
  logic [15:0] tempReg;
  logic [15:0] rxShift;
  logic [15:0] txShift;
  logic [4:0] bitCount;
  logic sclkRise;
  logic sclkFall;
  logic frameEnd;
  logic [15:0] sampleIn [3];

  assign sampleIn[0] = velIncX;
  assign sampleIn[1] = velIncY;
  assign sampleIn[2] = velIncZ;

  function automatic logic [31:0] absMag(input logic [31:0] v);
    absMag = v[31] ? 32'(~v + 32'h1) : v;
  endfunction : absMag

  function automatic logic [15:0] satVel(input logic [31:0] q, input logic neg);
    if (!neg) begin
      satVel = (q > VEL_POS_LIMIT) ? VEL_POS_LIMIT[15:0] : q[15:0];
    end else begin
      satVel = (q > VEL_NEG_LIMIT) ? VEL_NEG_LIMIT[15:0] : 16'(~q[15:0] + 16'h1);
    end
  endfunction : satVel

  // one restoring division step: returns {remainder, quotient, dividend}
  function automatic logic [81:0] divStep(input logic [17:0] r, input logic [31:0] q,
                                          input logic [31:0] d, input logic [16:0] n);
    logic [17:0] t;
    t = {r[16:0], d[31]};
    if (t >= {1'b0, n}) begin
      divStep = {18'(t - {1'b0, n}), q[30:0], 1'b1, d[30:0], 1'b0};
    end else begin
      divStep = {t, q[30:0], 1'b0, d[30:0], 1'b0};
    end
  endfunction : divStep

  function automatic logic [15:0] readReg(input logic [6:0] a, input logic [15:0] t,
                                          input logic [15:0] vx, input logic [15:0] vy,
                                          input logic [15:0] vz);
    logic [6:0] w;
    w = {a[6:1], 1'b0};
    if (w == TEMPERATURE_OUTPUT_ADDR) readReg = t;
    else if (w == X_VELOCITY_CHANGE_ADDR) readReg = vx;
    else if (w == Y_VELOCITY_CHANGE_ADDR) readReg = vy;
    else if (w == Z_VELOCITY_CHANGE_ADDR) readReg = vz;
    else if (w == LOT_CODE_FIRST_HALF_ADDR) readReg = LOT_FIRST;
    else if (w == LOT_CODE_SECOND_HALF_ADDR) readReg = LOT_SECOND;
    else if (w == PART_IDENTITY_ADDR) readReg = PART_ID;
    else if (w == UNIT_SERIAL_NUMBER_ADDR) readReg = SERIAL_CODE;
    else readReg = 16'h0000;
  endfunction : readReg

  // pin synchronisers; only stage 1 onward is read by logic
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      extSync <= 3'h0;
      sclkSync <= 3'h7;
      csSync <= 3'h7;
      mosiSync <= 2'h0;
    end else begin
      extSync <= {extSync[1:0], extSampleClk};
      sclkSync <= {sclkSync[1:0], sclk};
      csSync <= {csSync[1:0], csN};
      mosiSync <= {mosiSync[0], mosi};
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || intCount == 32'(TICK_CYCLES - 1)) begin
      intCount <= 32'h0;
    end else begin
      intCount <= intCount + 32'h1;
    end
  end

  assign intTick = (intCount == 32'(TICK_CYCLES - 1));
  assign extRise = extSync[1] && !extSync[2];
  assign sampleTick = (clockModeSel == CLK_MODE_INTERNAL) ? intTick : extRise;
  assign windowEnd = sampleTick && (sampleCount >= decimationSetting);

  always_ff @(posedge clk) begin
    if (!reset_n || windowEnd) begin
      sampleCount <= 16'h0;
    end else if (sampleTick) begin
      sampleCount <= sampleCount + 16'h1;
    end
  end

  // accumulate increments over decimation + 1 samples, then divide by that count
  always_ff @(posedge clk) begin
    logic [31:0] sum;
    sum = 32'h0;
    if (!reset_n) begin
      for (int i = 0; i < 3; i++) begin
        accum[i] <= 32'sh0;
        magSave[i] <= 32'h0;
        negSign[i] <= 1'b0;
      end
      divisor <= 17'h1;
    end else if (sampleTick) begin
      for (int i = 0; i < 3; i++) begin
        sum = 32'(accum[i] + {{16{sampleIn[i][15]}}, sampleIn[i]});
        if (windowEnd) begin
          accum[i] <= 32'sh0;
          magSave[i] <= absMag(sum);
          negSign[i] <= sum[31];
        end else begin
          accum[i] <= sum;
        end
      end
      if (windowEnd) begin
        divisor <= 17'({1'b0, decimationSetting} + 17'h1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      divCount <= 6'h0;
      dvLoad <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        rem[i] <= 18'h0;
        quo[i] <= 32'h0;
        dvd[i] <= 32'h0;
      end
    end else begin
      dvLoad <= (divCount == 6'h1);
      if (windowEnd) begin
        divCount <= DIV_STEPS_COUNT;
        for (int i = 0; i < 3; i++) begin
          rem[i] <= 18'h0;
          quo[i] <= 32'h0;
          dvd[i] <= absMag(32'(accum[i] + {{16{sampleIn[i][15]}}, sampleIn[i]}));
        end
      end else if (divCount != 6'h0) begin
        divCount <= divCount - 6'h1;
        for (int i = 0; i < 3; i++) begin
          {rem[i], quo[i], dvd[i]} <= divStep(rem[i], quo[i], dvd[i], divisor);
        end
      end
    end
  end

  // only the processing path writes these; the serial port has no write path
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < 3; i++) velReg[i] <= VEL_ZERO;
    end else if (dvLoad) begin
      for (int i = 0; i < 3; i++) velReg[i] <= satVel(quo[i], negSign[i]);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tempReg <= TEMP_ZERO;
    end else if (tempValid) begin
      tempReg <= tempData;
    end
  end

  assign sclkRise = sclkSync[1] && !sclkSync[2];
  assign sclkFall = !sclkSync[1] && sclkSync[2];
  assign frameEnd = csSync[1] && !csSync[2];

  // serial slave: command frame answered in the following frame
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rxShift <= 16'h0;
      txShift <= 16'h0;
      bitCount <= 5'h0;
    end else if (frameEnd) begin
      bitCount <= 5'h0;
      if (bitCount == FRAME_BITS_COUNT && !rxShift[CMD_WRITE_BIT]) begin
        txShift <= readReg(rxShift[CMD_ADDR_HI:CMD_ADDR_LO], tempReg, velReg[0], velReg[1], velReg[2]);
      end else begin
        txShift <= 16'h0;
      end
    end else if (!csSync[1]) begin
      if (sclkRise) begin
        rxShift <= {rxShift[FRAME_BITS-2:0], mosiSync[1]};
        bitCount <= 5'(bitCount + 5'h1);
      end else if (sclkFall && bitCount != 5'h0) begin
        txShift <= {txShift[FRAME_BITS-2:0], 1'b0};
      end
    end
  end

  assign miso = txShift[FRAME_BITS-1];
  assign misoEnable = !csSync[1];

  property p_dv_timing;
    @(posedge clk) disable iff (!reset_n)
    windowEnd |-> ##33 dvLoad;
  endproperty
  a_dv_timing: assert property (p_dv_timing) else $error("velocity load late");

  property p_dv_value;
    @(posedge clk) disable iff (!reset_n)
    dvLoad |=> velReg[0] == satVel($past(quo[0]), $past(negSign[0]));
  endproperty
  a_dv_value: assert property (p_dv_value) else $error("x velocity value wrong");

  property p_div_scale;
    @(posedge clk) disable iff (!reset_n)
    dvLoad |-> (64'(quo[1]) * 64'(divisor) + 64'(rem[1]) == 64'(magSave[1])) && (rem[1] < 18'(divisor));
  endproperty
  a_div_scale: assert property (p_div_scale) else $error("velocity scaling wrong");

  property p_ext_clock;
    @(posedge clk) disable iff (!reset_n)
    (clockModeSel != CLK_MODE_INTERNAL && !extSync[2] && extSync[1]) |-> sampleTick;
  endproperty
  a_ext_clock: assert property (p_ext_clock) else $error("external sample edge missed");

  property p_temp_load;
    @(posedge clk) disable iff (!reset_n)
    tempValid |=> tempReg == $past(tempData);
  endproperty
  a_temp_load: assert property (p_temp_load) else $error("temperature not loaded");

  property p_temp_hold;
    @(posedge clk) disable iff (!reset_n)
    !tempValid |=> $stable(tempReg);
  endproperty
  a_temp_hold: assert property (p_temp_hold) else $error("temperature changed");

  property p_part_read;
    @(posedge clk) disable iff (!reset_n)
    (frameEnd && bitCount == FRAME_BITS_COUNT && !rxShift[CMD_WRITE_BIT]
      && rxShift[CMD_ADDR_HI:CMD_ADDR_LO] == PART_IDENTITY_ADDR) |=> txShift == PART_ID;
  endproperty
  a_part_read: assert property (p_part_read) else $error("part identity wrong");

  property p_lot_read;
    @(posedge clk) disable iff (!reset_n)
    (frameEnd && bitCount == FRAME_BITS_COUNT && !rxShift[CMD_WRITE_BIT]
      && rxShift[CMD_ADDR_HI:CMD_ADDR_LO] == LOT_CODE_SECOND_HALF_ADDR) |=> txShift == LOT_SECOND;
  endproperty
  a_lot_read: assert property (p_lot_read) else $error("lot code wrong");

  property p_serial_read;
    @(posedge clk) disable iff (!reset_n)
    (frameEnd && bitCount == FRAME_BITS_COUNT && !rxShift[CMD_WRITE_BIT]
      && rxShift[CMD_ADDR_HI:CMD_ADDR_LO] == UNIT_SERIAL_NUMBER_ADDR)
      |=> txShift[SERIAL_BITS-1:0] == SERIAL_CODE[SERIAL_BITS-1:0];
  endproperty
  a_serial_read: assert property (p_serial_read) else $error("serial number wrong");

  property p_vel_hold;
    @(posedge clk) disable iff (!reset_n)
    !dvLoad |=> $stable(velReg[0]) && $stable(velReg[1]) && $stable(velReg[2]);
  endproperty
  a_vel_hold: assert property (p_vel_hold) else $error("velocity changed without load");

  property p_write_ignored;
    @(posedge clk) disable iff (!reset_n)
    (frameEnd && rxShift[CMD_WRITE_BIT] && !tempValid) |=> txShift == 16'h0000 && $stable(tempReg);
  endproperty
  a_write_ignored: assert property (p_write_ignored) else $error("write had an effect");
endmodule : iodr_registers
`default_nettype wire

// *** tb/iodr_host_model.sv ***
/*
  Host controller model: runs 16-bit mode 3 serial frames on the register port.
  Assumes a 125 MHz clk and phases of at least 4 clk, as the slave needs.
*/
`timescale 1ns/1ps
`default_nettype none
module iodr_host_model (
  input wire logic clk,
  input wire logic miso,
  output var logic sclk,
  output var logic csN,
  output var logic mosi
);
  initial begin
    sclk = 1'b1;
    csN = 1'b1;
    mosi = 1'b0;
  end

  // one frame: command out msb first, answer of the previous frame sampled on sclk rise
  task automatic xfer(input logic [15:0] cmd, output logic [15:0] rx);
    int i;
    @(posedge clk);
    csN <= 1'b0;
    for (i = 15; i >= 0; i--) begin
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
      mosi <= cmd[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      rx[i] = miso;
    end
    repeat (4) @(posedge clk);
    csN <= 1'b1;
    // released data line does not keep its last level
    mosi <= ~cmd[0];
    repeat (6) @(posedge clk);
  endtask : xfer
endmodule : iodr_host_model
`default_nettype wire

// *** tb/test_inertial_output_id_registers.sv ***
/*
  Self-checking bench for the output and identification registers.
  Assumes the host model above and a shortened internal tick of 50 clk.
*/
`timescale 1ns/1ps
`default_nettype none
module test_inertial_output_id_registers;
  import iodr_pkg::*;
  localparam logic [15:0] PID = 16'h0C3D; // arbitrary value
  localparam logic [15:0] LOT1 = 16'h1357; // arbitrary value
  localparam logic [15:0] LOT2 = 16'h2468; // arbitrary value
  localparam logic [15:0] SNUM = 16'h3FFE; // arbitrary value
  localparam int LIMIT = 30000;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] clockModeSel = 2'h1;
  logic [15:0] decimationSetting = 16'h0001;
  logic extSampleClk = 1'b0;
  logic [15:0] velIncX = 16'h0000;
  logic [15:0] velIncY = 16'h0000;
  logic [15:0] velIncZ = 16'h0000;
  logic tempValid = 1'b0;
  logic [15:0] tempData = 16'h0000;
  wire logic sclk;
  wire logic csN;
  wire logic mosi;
  wire logic miso;
  wire logic misoEnable;
  int failCount = 0;
  int checked = 0;
  int cycles = 0;
  logic [15:0] v;

  iodr_registers #(.TICK_CYCLES(50), .PART_ID(PID), .LOT_FIRST(LOT1), .LOT_SECOND(LOT2),
    .SERIAL_CODE(SNUM)) dut (.clk(clk), .reset_n(reset_n), .clockModeSel(clockModeSel),
    .decimationSetting(decimationSetting), .extSampleClk(extSampleClk), .velIncX(velIncX),
    .velIncY(velIncY), .velIncZ(velIncZ), .tempValid(tempValid), .tempData(tempData),
    .sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso), .misoEnable(misoEnable));
  iodr_host_model host (.clk(clk), .miso(miso), .sclk(sclk), .csN(csN), .mosi(mosi));

  initial begin
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failCount++;
      $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  // read takes two frames: the answer comes back during the following one
  task automatic rd(input logic [6:0] addr, input logic [15:0] exp, input logic [15:0] mask);
    logic [15:0] rx;
    host.xfer({1'b0, addr, 8'h00}, rx);
    host.xfer(16'h0000, rx);
    check(rx & mask, exp);
  endtask : rd

  // external sample edge with the increments held for the whole pulse
  task automatic tick(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
    velIncX <= x;
    velIncY <= y;
    velIncZ <= z;
    extSampleClk <= 1'b1;
    repeat (10) @(posedge clk);
    extSampleClk <= 1'b0;
    repeat (40) @(posedge clk);
  endtask : tick

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failCount++;
      conclude();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    check({15'h0000, misoEnable}, 16'h0000);
    rd(X_VELOCITY_CHANGE_ADDR, VEL_ZERO, 16'hFFFF);
    rd(TEMPERATURE_OUTPUT_ADDR, TEMP_ZERO, 16'hFFFF);
    $display("test reset values done");
    rd(PART_IDENTITY_ADDR, PID, 16'hFFFF);
    rd(LOT_CODE_FIRST_HALF_ADDR, LOT1, 16'hFFFF);
    rd(LOT_CODE_SECOND_HALF_ADDR, LOT2, 16'hFFFF);
    rd(UNIT_SERIAL_NUMBER_ADDR, 16'h0FFE, 16'h0FFF);
    rd(7'h10, 16'h0000, 16'hFFFF);
    $display("test identification done");
    tempData <= 16'hFAEC;
    tempValid <= 1'b1;
    @(posedge clk);
    tempValid <= 1'b0;
    rd(TEMPERATURE_OUTPUT_ADDR, 16'hFAEC, 16'hFFFF);
    $display("test temperature done");
    host.xfer({1'b1, TEMPERATURE_OUTPUT_ADDR, 8'h55}, v);
    host.xfer({1'b1, PART_IDENTITY_ADDR, 8'hAA}, v);
    check(v, 16'h0000);
    // the data line must be driven while the frame is open
    fork
      host.xfer(16'h0000, v);
      begin
        repeat (8) @(posedge clk);
        check({15'h0000, misoEnable}, 16'h0001);
      end
    join
    check(v, 16'h0000);
    rd(TEMPERATURE_OUTPUT_ADDR, 16'hFAEC, 16'hFFFF);
    rd(PART_IDENTITY_ADDR, PID, 16'hFFFF);
    $display("test write refusal done");
    // two-sample window: mean of the increments, truncated toward zero
    tick(16'h0003, 16'hFFFD, 16'h7FFF);
    tick(16'h0006, 16'hFFFA, 16'h7FFF);
    rd(X_VELOCITY_CHANGE_ADDR, 16'h0004, 16'hFFFF);
    rd(Y_VELOCITY_CHANGE_ADDR, 16'hFFFC, 16'hFFFF);
    rd(Z_VELOCITY_CHANGE_ADDR, 16'h7FFF, 16'hFFFF);
    $display("test external sample clock done");
    clockModeSel <= CLK_MODE_INTERNAL;
    decimationSetting <= 16'h0000;
    velIncX <= 16'h0005;
    velIncY <= 16'h8000;
    velIncZ <= 16'hFFFF;
    repeat (300) @(posedge clk);
    rd(X_VELOCITY_CHANGE_ADDR, 16'h0005, 16'hFFFF);
    rd(Y_VELOCITY_CHANGE_ADDR, 16'h8000, 16'hFFFF);
    rd(Z_VELOCITY_CHANGE_ADDR, 16'hFFFF, 16'hFFFF);
    $display("test internal sample clock done");
    conclude();
  end
endmodule : test_inertial_output_id_registers
`default_nettype wire
